/* rtl/asx_pkg.sv */
// Constants, register layout and helpers for the audio serial transmit port.
// Assumes a single 10 MHz system clock and a register port on the same clock.
package asx_pkg;
  localparam logic [7:0] ADDR_FORMAT_CFG = 8'h07;
  localparam logic [7:0] ADDR_DRIVE_CFG = 8'h08;
  localparam logic [7:0] RESET_FORMAT_CFG = 8'h30;
  localparam logic [7:0] RESET_DRIVE_CFG = 8'h00;
  // Field positions in the format register.
  localparam int FORMAT_MSB = 7;
  localparam int FORMAT_LSB = 6;
  localparam int WLEN_MSB = 5;
  localparam int WLEN_LSB = 4;
  localparam int FS_INV_BIT = 3;
  localparam int BCLK_INV_BIT = 2;
  localparam int TX_EDGE_BIT = 1;
  localparam int FILL_BIT = 0;
  // Field positions in the drive register.
  localparam int LSB_HIZ_BIT = 7;
  localparam int KEEP_MSB = 6;
  localparam int KEEP_LSB = 5;
  localparam int OFFSET_MSB = 4;
  localparam int OFFSET_LSB = 0;
  typedef enum logic [1:0] {
    FMT_TDM = 2'h0,
    FMT_I2S = 2'h1,
    FMT_LJ = 2'h2,
    FMT_RSVD = 2'h3
  } asx_format_t;
  typedef enum logic [1:0] {
    KEEP_OFF = 2'h0,
    KEEP_ON = 2'h1,
    KEEP_LSB_ONE = 2'h2,
    KEEP_LSB_ONE_HALF = 2'h3
  } asx_keep_t;
  // Bit-clock half period in system clock cycles; a frame ends at bit FRAME_LAST.
  localparam logic [7:0] BCLK_HALF_CYCLES = 8'h02;
  localparam logic [6:0] FRAME_LAST = 7'h7f;
  localparam logic [1:0] KEEP_HALVES_ONE = 2'h2;
  localparam logic [1:0] KEEP_HALVES_ONE_HALF = 2'h3;
  localparam logic [5:0] I2S_DELAY = 6'h01;

  function automatic logic [6:0] asx_wlen_bits(input logic [1:0] code);
    case (code)
      2'h0: asx_wlen_bits = 7'h10;
      2'h1: asx_wlen_bits = 7'h14;
      2'h2: asx_wlen_bits = 7'h18;
      default: asx_wlen_bits = 7'h20;
    endcase
  endfunction
endpackage

/* rtl/asx_pin_drv.sv */
// Output stage for one serial data pin: registered level and active-low enable.
// Assumes launch and half_tick are one-cycle enables from the transmitter.
`timescale 1ns/1ps
module asx_pin_drv (
  input wire logic clock,
  input wire logic rstn,
  input wire logic launch,
  input wire logic half_tick,
  input wire logic bit_val,
  input wire logic active,
  input wire logic fill_hiz,
  input wire logic lsb_now,
  input wire logic lsb_hiz,
  output logic pin_out,
  output logic pin_oe_n
);
  logic release_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
      release_reg <= 1'b0;
    end else if (launch) begin
      if (active) begin
        pin_out <= bit_val;
        pin_oe_n <= 1'b0;
        release_reg <= lsb_now & lsb_hiz;
      end else begin
        pin_out <= 1'b0;
        pin_oe_n <= fill_hiz;
        release_reg <= 1'b0;
      end
    end else if (half_tick && release_reg) begin
      pin_oe_n <= 1'b1;
      release_reg <= 1'b0;
    end
  end
endmodule

/* rtl/asx_tx.sv */
// Audio serial transmitter: bit clock, frame sync and two data pins, with config registers.
// Assumes the register port and sample words are driven on the same clock.
`timescale 1ns/1ps
// Function
// - The format field picks TDM for 0, I2S for 1 and left-justified for 2, with 3 not to be used.
// - The word length field, reset to 3, gives slots of 16, 20, 24 or 32 bits.
// - The frame-sync and bit-clock invert bits each flip their line against the standard.
// - The transmit edge bit moves data launch to the opposite bit-clock edge, half a cycle later.
// - Cycles without slot data drive zero, or high impedance when the fill bit is set.
// - The LSB bit makes the LSB drive for half a cycle and then release the pin.
// - The keeper field selects off, always on, on one cycle at LSB, or on one and a half at LSB.
// - The offset field delays slot 0 MSB by 0 to 31 bit clocks, both halves in I2S and LJ.
// - All drive settings apply equally to the primary and secondary data pins.
module asx_tx (
  input wire logic clock,
  input wire logic rstn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [31:0] pri_left_word,
  input wire logic [31:0] pri_right_word,
  input wire logic [31:0] sec_left_word,
  input wire logic [31:0] sec_right_word,
  output logic sample_take,
  output logic bit_clock,
  output logic frame_sync,
  output logic [1:0] data_out,
  output logic [1:0] data_oe_n,
  output logic keeper_en
);
  import asx_pkg::*;

  logic [7:0] format_cfg_reg;
  logic [7:0] drive_cfg_reg;
  logic [7:0] div_reg;
  logic half_tick;
  logic bclk_std_reg;
  logic bclk_std_next;
  logic [6:0] bit_cnt_reg;
  logic fall_tick;
  logic launch_tick;
  logic [6:0] launch_cnt;
  logic [6:0] frame_next;
  asx_format_t fmt;
  logic [6:0] wlen;
  logic [5:0] start;
  logic [6:0] rel;
  logic active;
  logic slot_sel;
  logic [5:0] pos;
  logic lsb_now;
  logic fs_std;
  logic [1:0] keep_cnt_reg;
  logic [31:0] word_reg [2][2];
  logic [31:0] word_in [2][2];
  logic [1:0] pin_bit;

  assign fmt = asx_format_t'(format_cfg_reg[FORMAT_MSB:FORMAT_LSB]);
  assign wlen = asx_wlen_bits(format_cfg_reg[WLEN_MSB:WLEN_LSB]);
  assign word_in[0][0] = pri_left_word;
  assign word_in[0][1] = pri_right_word;
  assign word_in[1][0] = sec_left_word;
  assign word_in[1][1] = sec_right_word;

  ////////////////////////////////////////////////////////////////////////////
  // Register port.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      format_cfg_reg <= RESET_FORMAT_CFG;
      drive_cfg_reg <= RESET_DRIVE_CFG;
    end else if (reg_wr_en) begin
      if (reg_addr == ADDR_FORMAT_CFG) begin
        format_cfg_reg <= reg_wdata;
      end else if (reg_addr == ADDR_DRIVE_CFG) begin
        drive_cfg_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      if (reg_addr == ADDR_FORMAT_CFG) begin
        reg_rdata <= format_cfg_reg;
      end else if (reg_addr == ADDR_DRIVE_CFG) begin
        reg_rdata <= drive_cfg_reg;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit-clock divider and bit counter.
  assign half_tick = (div_reg == BCLK_HALF_CYCLES - 8'h01);
  assign bclk_std_next = half_tick ? ~bclk_std_reg : bclk_std_reg;
  assign fall_tick = half_tick & bclk_std_reg;
  assign frame_next = bit_cnt_reg + 7'h01;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 8'h00;
      bclk_std_reg <= 1'b0;
      bit_cnt_reg <= FRAME_LAST;
    end else begin
      div_reg <= half_tick ? 8'h00 : div_reg + 8'h01;
      bclk_std_reg <= bclk_std_next;
      if (fall_tick) begin
        bit_cnt_reg <= frame_next;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bit_clock <= 1'b0;
      frame_sync <= 1'b0;
    end else begin
      bit_clock <= bclk_std_next ^ format_cfg_reg[BCLK_INV_BIT];
      if (fall_tick) begin
        frame_sync <= fs_std ^ format_cfg_reg[FS_INV_BIT];
      end
    end
  end

  always_comb begin
    case (fmt)
      FMT_I2S: fs_std = frame_next[6];
      FMT_LJ: fs_std = ~frame_next[6];
      default: fs_std = (frame_next == 7'h00);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot position of the bit being launched.
  assign launch_tick = half_tick & (bclk_std_reg != format_cfg_reg[TX_EDGE_BIT]);
  assign launch_cnt = format_cfg_reg[TX_EDGE_BIT] ? bit_cnt_reg : frame_next;
  assign start = drive_cfg_reg[OFFSET_MSB:OFFSET_LSB] + ((fmt == FMT_I2S) ? I2S_DELAY : 6'h00);

  always_comb begin
    rel = 7'h00;
    active = 1'b0;
    slot_sel = 1'b0;
    pos = 6'h00;
    if (fmt == FMT_I2S || fmt == FMT_LJ) begin
      rel = {1'b0, launch_cnt[5:0]} - {1'b0, start};
      active = (launch_cnt[5:0] >= start) && (rel < wlen);
      slot_sel = launch_cnt[6];
      pos = rel[5:0];
    end else begin
      rel = launch_cnt - {1'b0, start};
      active = (launch_cnt >= {1'b0, start}) && (rel < (wlen << 1));
      slot_sel = (rel >= wlen);
      pos = slot_sel ? 6'(rel - wlen) : rel[5:0];
    end
  end

  assign lsb_now = ({1'b0, pos} == wlen - 7'h01);

  ////////////////////////////////////////////////////////////////////////////
  // Sample words, taken just before each frame starts.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sample_take <= 1'b0;
      for (int p = 0; p < 2; p++) begin
        word_reg[p][0] <= 32'h0000_0000;
        word_reg[p][1] <= 32'h0000_0000;
      end
    end else begin
      sample_take <= fall_tick && (bit_cnt_reg == FRAME_LAST);
      if (fall_tick && (bit_cnt_reg == FRAME_LAST)) begin
        word_reg <= word_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data pins share every drive setting.
  for (genvar p = 0; p < 2; p++) begin : g_pin
    logic [31:0] word_now;
    assign word_now = (fall_tick && bit_cnt_reg == FRAME_LAST) ?
                      word_in[p][slot_sel] : word_reg[p][slot_sel];
    assign pin_bit[p] = word_now[5'(6'd31 - pos)];
    asx_pin_drv u_drv (
      .clock(clock),
      .rstn(rstn),
      .launch(launch_tick),
      .half_tick(half_tick),
      .bit_val(pin_bit[p]),
      .active(active),
      .fill_hiz(format_cfg_reg[FILL_BIT]),
      .lsb_now(lsb_now),
      .lsb_hiz(drive_cfg_reg[LSB_HIZ_BIT]),
      .pin_out(data_out[p]),
      .pin_oe_n(data_oe_n[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus keeper, counted in bit-clock half periods.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      keep_cnt_reg <= 2'h0;
      keeper_en <= 1'b0;
    end else begin
      if (launch_tick && active && lsb_now) begin
        if (drive_cfg_reg[KEEP_MSB:KEEP_LSB] == KEEP_LSB_ONE) begin
          keep_cnt_reg <= KEEP_HALVES_ONE;
        end else if (drive_cfg_reg[KEEP_MSB:KEEP_LSB] == KEEP_LSB_ONE_HALF) begin
          keep_cnt_reg <= KEEP_HALVES_ONE_HALF;
        end
      end else if (half_tick && keep_cnt_reg != 2'h0) begin
        keep_cnt_reg <= keep_cnt_reg - 2'h1;
      end
      if (drive_cfg_reg[KEEP_MSB:KEEP_LSB] == KEEP_ON) begin
        keeper_en <= 1'b1;
      end else if (drive_cfg_reg[KEEP_MSB:KEEP_LSB] == KEEP_OFF) begin
        keeper_en <= 1'b0;
      end else begin
        keeper_en <= (launch_tick && active && lsb_now) || (keep_cnt_reg > 2'h1) ||
                     (keep_cnt_reg == 2'h1 && !half_tick);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  fs_i2s_left_a: assert property (fall_tick && fmt == FMT_I2S && frame_next == 7'h00 |=>
    frame_sync == format_cfg_reg[FS_INV_BIT]) else $error("I2S left half frame sync wrong");
  slot_split_a: assert property (launch_tick && fmt == FMT_TDM && active &&
    rel == wlen |-> slot_sel && pos == 6'h00) else $error("TDM slot 1 start wrong");
  bclk_invert_a: assert property (bit_clock == (bclk_std_reg ^ $past(format_cfg_reg[BCLK_INV_BIT])))
    else $error("bit clock polarity wrong");
  launch_only_a: assert property ($changed(data_oe_n[0]) |-> $past(launch_tick) ||
    $past(half_tick)) else $error("data pin moved off a tick");
  fill_hiz_a: assert property (launch_tick && !active && format_cfg_reg[FILL_BIT] |=>
    data_oe_n[0]) else $error("unused cycle not released");
  lsb_half_a: assert property (launch_tick && active && lsb_now &&
    drive_cfg_reg[LSB_HIZ_BIT] |=> !data_oe_n[0] ##2 data_oe_n[0]) else $error("LSB not released");
  keeper_long_a: assert property (launch_tick && active && lsb_now &&
    drive_cfg_reg[KEEP_MSB:KEEP_LSB] == KEEP_LSB_ONE_HALF && $stable(drive_cfg_reg) |=>
    keeper_en [*6] ##1 !keeper_en) else $error("keeper length wrong");
  lj_offset_a: assert property (launch_tick && fmt == FMT_LJ &&
    launch_cnt[5:0] == drive_cfg_reg[OFFSET_MSB:OFFSET_LSB] |-> active && pos == 6'h00)
    else $error("slot 0 MSB offset wrong");
  pins_alike_a: assert property (data_oe_n[0] == data_oe_n[1])
    else $error("pins differ in drive");

  cover_i2s_c: cover property (fmt == FMT_I2S && sample_take);
  cover_lsb_c: cover property (launch_tick && active && lsb_now && drive_cfg_reg[LSB_HIZ_BIT]);
  cover_keep_c: cover property (keeper_en && drive_cfg_reg[KEEP_MSB:KEEP_LSB] == KEEP_LSB_ONE);
endmodule

/* tb/asx_host_rx.sv */
// Host receiver model: captures one 128-bit frame per data pin from the serial lines.
// Assumes the bench mirrors the format register value on cfg.
`timescale 1ns/1ps
module asx_host_rx (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] cfg,
  input wire logic bit_clock,
  input wire logic frame_sync,
  input wire logic [1:0] data_out,
  input wire logic [1:0] data_oe_n,
  output logic [127:0] frame0,
  output logic [127:0] frame1,
  output logic frame_done
);
  logic bclk_prev, fs_prev, samp, start_lvl;
  logic [1:0] last, lvl;
  logic [6:0] cnt, cnt_now, pos;
  // Sample on the edge opposite launch, which follows both invert and edge bits.
  assign samp = (bit_clock != bclk_prev) && (bit_clock == !(cfg[2] ^ cfg[1]));
  assign start_lvl = (cfg[7:6] != 2'h1) ^ cfg[3];
  assign cnt_now = (frame_sync == start_lvl && fs_prev != start_lvl) ? 7'h00 : cnt + 7'h01;
  assign pos = cfg[1] ? cnt_now - 7'h01 : cnt_now;
  // A released pin reads as the inverse of its last level.
  assign lvl[0] = data_oe_n[0] ? ~last[0] : data_out[0];
  assign lvl[1] = data_oe_n[1] ? ~last[1] : data_out[1];
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bclk_prev <= 1'b0;
      fs_prev <= 1'b0;
      cnt <= 7'h00;
      last <= 2'h0;
      frame_done <= 1'b0;
      frame0 <= '0;
      frame1 <= '0;
    end else begin
      bclk_prev <= bit_clock;
      frame_done <= samp && pos == 7'h7f;
      if (samp) begin
        fs_prev <= frame_sync;
        cnt <= cnt_now;
        last <= lvl;
        frame0[pos] <= lvl[0];
        frame1[pos] <= lvl[1];
      end
    end
  end
endmodule

/* tb/audio_serial_tx_format_config_tb.sv */
// Bench for the audio serial transmitter: registers, framing, drive and keeper.
// Assumes asx_host_rx stands on the serial side.
`timescale 1ns/1ps
module audio_serial_tx_format_config_tb;
  import asx_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] cfg0 = 8'h30;
  logic [7:0] reg_rdata, rd;
  logic [31:0] wd [4] = '{32'ha5c3_9e71, 32'h1b2d_3c4e, 32'h6f80_0f17, 32'hc0de_5a96};
  logic [7:0] cf0 [6] = '{8'h30, 8'h08, 8'h64, 8'h92, 8'h7e, 8'h88};
  logic [7:0] cf1 [6] = '{8'h00, 8'h1f, 8'h05, 8'h03, 8'h00, 8'h1f};
  int kexp [4] = '{0, 512, 8, 12};
  logic sample_take, bit_clock, frame_sync, keeper_en, frame_done;
  logic [1:0] data_out, data_oe_n;
  logic [127:0] frame0, frame1;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  int kc, d0, d1, st;
  asx_tx i_asx_tx (.clock(clock), .rstn(rstn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pri_left_word(wd[0]), .pri_right_word(wd[1]), .sec_left_word(wd[2]),
    .sec_right_word(wd[3]), .sample_take(sample_take), .bit_clock(bit_clock),
    .frame_sync(frame_sync), .data_out(data_out), .data_oe_n(data_oe_n), .keeper_en(keeper_en));
  asx_host_rx i_asx_host_rx (.clock(clock), .rstn(rstn), .cfg(cfg0), .bit_clock(bit_clock),
    .frame_sync(frame_sync), .data_out(data_out), .data_oe_n(data_oe_n), .frame0(frame0),
    .frame1(frame1), .frame_done(frame_done));
  initial begin
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr_en = 1'b0;
    if (a == ADDR_FORMAT_CFG) cfg0 = d;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd_en = 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask
  task automatic wait_frames(input int n);
    repeat (n) begin
      @(negedge clock);
      while (frame_done !== 1'b1) @(negedge clock);
    end
  endtask
  task automatic measure();
    kc = 0;
    d0 = 0;
    d1 = 0;
    st = 0;
    repeat (512) begin
      @(negedge clock);
      st += (sample_take === 1'b1);
      kc += (keeper_en === 1'b1);
      d0 += (data_oe_n[0] === 1'b0);
      d1 += (data_oe_n[1] === 1'b0);
    end
  endtask
  function automatic logic [127:0] exp_frame(input logic [7:0] c0, input logic [7:0] c1,
      input logic [31:0] lw, input logic [31:0] rw);
    logic [127:0] f;
    logic [31:0] wv;
    int w, q, s;
    f = '0;
    w = (c0[5:4] == 2'h3) ? 32 : 16 + 4 * c0[5:4];
    for (int p = 0; p < 128; p++) begin
      q = (c0[7:6] == 2'h0) ? p : p % 64;
      s = c1[4:0] + ((c0[7:6] == 2'h1) ? 1 : 0);
      wv = (c0[7:6] != 2'h0 && p >= 64) ? rw : lw;
      if (c0[7:6] == 2'h0 && q >= s + w) begin
        wv = rw;
        s = s + w;
      end
      if (q >= s && q < s + w) f[p] = wv[31 - (q - s)];
    end
    return f;
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    reg_read(ADDR_FORMAT_CFG, rd);
    check("format reset", 128'(rd), 128'(RESET_FORMAT_CFG));
    reg_read(ADDR_DRIVE_CFG, rd);
    check("drive reset", 128'(rd), 128'(RESET_DRIVE_CFG));
    reg_read(8'h09, rd);
    check("unmapped read", 128'(rd), 128'h0);
    reg_write(ADDR_FORMAT_CFG, 8'hf0);
    reg_read(ADDR_FORMAT_CFG, rd);
    check("reserved format", 128'(rd), 128'hf0);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      reg_write(ADDR_FORMAT_CFG, cf0[i]);
      reg_write(ADDR_DRIVE_CFG, cf1[i]);
      wait_frames(3);
      check("primary frame", frame0, exp_frame(cf0[i], cf1[i], wd[0], wd[1]));
      check("secondary frame", frame1, exp_frame(cf0[i], cf1[i], wd[2], wd[3]));
    end
    $display("test framing done");
    reg_write(ADDR_FORMAT_CFG, 8'h31);
    for (int k = 0; k < 4; k++) begin
      reg_write(ADDR_DRIVE_CFG, 8'(k << 5));
      wait_frames(1);
      measure();
      check("keeper cycles", 128'(kc), 128'(kexp[k]));
      check("driven cycles", 128'(d0), 128'd256);
      check("sample strobes", 128'(st), 128'd1);
    end
    reg_write(ADDR_DRIVE_CFG, 8'h80);
    wait_frames(1);
    measure();
    check("lsb release primary", 128'(d0), 128'd252);
    check("lsb release secondary", 128'(d1), 128'd252);
    reg_write(ADDR_FORMAT_CFG, 8'h30);
    wait_frames(1);
    measure();
    check("zero fill", 128'(d0), 128'd508);
    $display("test drive done");
    give_verdict();
  end
endmodule
